// ==== hw/pmi_pkg.sv ====
// Purpose: shared constants and types of the power-mode and interrupt block
// Assumes: register index = printed offset, byte address = index * 4
// Notes: vector slot 6 is skipped, it belongs to the debugger
package pmi_pkg;
  localparam int NSRC = 11;
  localparam int NLVL = 4;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_OPTION = 8'h94;
  localparam logic [7:0] IDX_PORT1_WAKE = 8'h96;
  localparam logic [7:0] IDX_INT_ENABLE = 8'hA0;
  localparam logic [7:0] IDX_PRIO_LOW = 8'hA1;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hA2;
  localparam logic [7:0] IDX_INT_FLAGS = 8'hA3;
  localparam logic [7:0] IDX_SERVICE = 8'hA4;
  localparam int PC_IDLE = 0;
  localparam int PC_STOP = 1;
  localparam int PC_GF_A = 2;
  localparam int PC_GF_B = 3;
  localparam int PC_BAUD = 7;
  localparam int OPT_PCH = 5;
  localparam int GLOBAL_EN = 15;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] OPT_RESET = 8'hC1;
  localparam logic [7:0] P1W_RESET = 8'h00;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_P1 = 4'h7;
  localparam logic [3:0] SRC_EXT2 = 4'h8;
  localparam logic [3:0] RSVD_SLOT = 4'h6;
  localparam logic [10:0] PIN_SRC_MASK = 11'h185;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_RSVD = 16'h0033;
  localparam logic [15:0] VEC_LAST = 16'h005B;

  typedef enum logic [1:0] {PMI_RUN, PMI_IDLE, PMI_STOP} pmi_mode_type;

  function automatic logic [15:0] pmi_vector(input logic [3:0] idx);
    logic [15:0] slot;
    slot = (idx < RSVD_SLOT) ? {12'h000, idx} : {12'h000, idx} + 16'h0001;
    return VEC_BASE + 16'(slot * VEC_STEP);
  endfunction

  function automatic logic [1:0] pmi_level(input logic [10:0] lo,
      input logic [10:0] hi, input logic [3:0] idx);
    return {hi[idx], lo[idx]};
  endfunction
endpackage

// ==== hw/pmi_svc_if.sv ====
// Purpose: carries pending, enable and priority state to the arbiter
// Assumes: single clock domain
// Notes: ack and ret are one-cycle pulses from the cpu
`timescale 1ns/100ps
`default_nettype none
interface pmi_svc_if;
  logic [10:0] pending;
  logic [10:0] enable;
  logic global_en;
  logic [10:0] prio_lo;
  logic [10:0] prio_hi;
  logic ack;
  logic ret;
  logic req;
  logic [15:0] vector;
  logic [3:0] active;
  modport arb(input pending, enable, global_en, prio_lo, prio_hi, ack, ret,
    output req, vector, active);
  modport ctl(output pending, enable, global_en, prio_lo, prio_hi, ack, ret,
    input req, vector, active);
endinterface
`default_nettype wire

// ==== hw/pmi_arbiter.sv ====
// Purpose: picks the winning source and tracks nested service levels
// Assumes: cpu pulses ack while req is high, ret at routine end
// Notes: ties inside a level go to the lowest source index
`timescale 1ns/100ps
`default_nettype none
module pmi_arbiter import pmi_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  pmi_svc_if.arb svc // service request group
);
  logic [1:0] win_lvl;
  logic [1:0] top_lvl;
  logic [1:0] req_lvl;
  logic [3:0] win_idx;
  logic [3:0] next_active;
  logic win_ok;
  logic top_ok;
  logic beats;
  always_comb begin
    win_ok = 1'b0;
    win_lvl = 2'h0;
    win_idx = 4'h0;
    top_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (svc.pending[i] && svc.enable[i] && svc.global_en && (!win_ok ||
          pmi_level(svc.prio_lo, svc.prio_hi, 4'(i)) >= win_lvl)) begin
        win_ok = 1'b1;
        win_lvl = pmi_level(svc.prio_lo, svc.prio_hi, 4'(i));
        win_idx = 4'(i);
      end
    end
    for (int l = 0; l < NLVL; l++) begin
      if (svc.active[l]) begin
        top_lvl = 2'(l);
      end
    end
  end
  assign top_ok = |svc.active;
  // equal level waits, only a strictly higher one preempts
  assign beats = win_ok && (!top_ok || win_lvl > top_lvl);
  always_comb begin
    next_active = svc.active;
    if (svc.ret && top_ok) begin
      next_active[top_lvl] = 1'b0;
    end
    if (svc.ack && svc.req) begin
      next_active[req_lvl] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      svc.req <= 1'b0;
      svc.vector <= 16'h0000;
      svc.active <= 4'h0;
      req_lvl <= 2'h0;
    end else begin
      svc.req <= beats && !svc.ack;
      svc.vector <= pmi_vector(win_idx);
      svc.active <= next_active;
      req_lvl <= win_lvl;
    end
  end
  chk_equal_waits: assert property (@(posedge clk) disable iff (!rst_b)
    (top_ok && win_ok && win_lvl <= top_lvl) |=> !svc.req)
    else $error("equal or lower level request was raised");
  chk_nest_push: assert property (@(posedge clk) disable iff (!rst_b)
    (svc.ack && svc.req && !svc.ret) |=> svc.active[$past(req_lvl)])
    else $error("acked level not marked active");
  chk_vector_map: assert property (@(posedge clk) disable iff (!rst_b)
    svc.req |-> (svc.vector != VEC_RSVD && svc.vector <= VEC_LAST))
    else $error("vector outside table");
  cov_preempt: cover property (@(posedge clk) disable iff (!rst_b)
    svc.ack && svc.req && top_ok);
endmodule // pmi_arbiter
`default_nettype wire

// ==== hw/pmi_mode_ctl.sv ====
// Purpose: run, idle and stop state machine with clock gate outputs
// Assumes: this logic sits on an always-on clock
// Notes: wake is combinational so request bits clear on the same edge
`timescale 1ns/100ps
`default_nettype none
module pmi_mode_ctl import pmi_pkg::*; (
  input wire logic clk, // always-on clock
  input wire logic rst_b, // sync reset, active low
  input wire logic idle_req, // idle request bit
  input wire logic stop_req, // power-down request bit
  input wire logic periph_halt, // stop timers and serial in idle
  input wire logic wake_idle, // enabled pending source
  input wire logic wake_stop, // enabled pin source pending
  output wire logic wake, // leaving a low-power state now
  output logic cpu_run, // cpu may execute
  output logic sysclk_en, // system clock running
  output logic periph_clk_en, // peripheral clocks running
  output logic timer_serial_clk_en // timers and uart clock running
);
  pmi_mode_type mode;
  pmi_mode_type next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PMI_RUN: begin
        if (stop_req) begin
          next_mode = PMI_STOP;
        end else if (idle_req) begin
          next_mode = PMI_IDLE;
        end
      end
      PMI_IDLE: begin
        if (wake_idle) begin
          next_mode = PMI_RUN;
        end
      end
      PMI_STOP: begin
        if (wake_stop) begin
          next_mode = PMI_RUN;
        end
      end
      // the unused fourth code falls back to run
      default: begin
        next_mode = PMI_RUN;
      end
    endcase
  end
  assign wake = (mode != PMI_RUN) && (next_mode == PMI_RUN);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= PMI_RUN;
      cpu_run <= 1'b1;
      sysclk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      timer_serial_clk_en <= 1'b1;
    end else begin
      mode <= next_mode;
      cpu_run <= next_mode == PMI_RUN;
      sysclk_en <= next_mode != PMI_STOP;
      periph_clk_en <= next_mode != PMI_STOP;
      timer_serial_clk_en <= (next_mode == PMI_RUN) ||
        (next_mode == PMI_IDLE && !periph_halt);
    end
  end
  chk_idle_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == PMI_IDLE && $stable(periph_halt)) |->
      timer_serial_clk_en == !periph_halt)
    else $error("idle timer clock gate wrong");
  chk_stop_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == PMI_STOP && !wake_stop) |=> mode == PMI_STOP)
    else $error("stop left without pin wake");
  chk_idle_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (mode == PMI_IDLE && wake_idle) |=> (mode == PMI_RUN && cpu_run))
    else $error("idle not left on enabled pending");
  cov_stop_wake: cover property (@(posedge clk) disable iff (!rst_b)
    mode == PMI_STOP && wake_stop);
endmodule // pmi_mode_ctl
`default_nettype wire

// ==== hw/pmi_top.sv ====
// Purpose: power-mode and interrupt/wake-up controller with apb registers
// Assumes: all inputs synchronous to clk; clk itself is never gated here
// Notes: byte address = register index * 4, upper address bits must be 0
`timescale 1ns/100ps
`default_nettype none
module pmi_top import pmi_pkg::*; (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst_b, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [10:0] src_event, // per-source event pulses
  input wire logic [2:0] ext_pin_input, // external interrupt pins
  input wire logic [7:0] port1_pin, // port1 pin levels
  input wire logic irq_ack, // cpu takes the vector
  input wire logic irq_return, // cpu ends a service routine
  output logic irq_req, // interrupt request to cpu
  output logic [15:0] irq_vector, // vector of the request
  output logic cpu_run, // cpu may execute
  output logic sysclk_en, // system clock enable
  output logic periph_clk_en, // peripheral clock enable
  output logic timer_serial_clk_en, // timer and uart clock enable
  output logic baud_doubler // serial baud doubler bit
);
  logic sleep_cpu_request;
  logic power_down_request;
  logic general_flag_a;
  logic general_flag_b;
  logic [7:0] option;
  logic [7:0] port1_wake_enable;
  logic [10:0] int_enable;
  logic global_enable;
  logic [10:0] prio_low;
  logic [10:0] prio_high;
  logic [10:0] flags;
  logic [2:0] ext_prev;
  logic [7:0] p1_prev;
  logic [10:0] next_flags;
  logic [31:0] rdata_mux;

  pmi_svc_if svc();

  // apb decode
  wire [7:0] reg_idx = paddr[9:2];
  wire in_range = paddr[11:10] == 2'h0;
  wire access = psel && penable && !pready;
  wire wr_en = access && pwrite;
  wire hit_pc = in_range && reg_idx == IDX_POWER_CONTROL;
  wire hit_opt = in_range && reg_idx == IDX_OPTION;
  wire hit_p1w = in_range && reg_idx == IDX_PORT1_WAKE;
  wire hit_ien = in_range && reg_idx == IDX_INT_ENABLE;
  wire hit_plo = in_range && reg_idx == IDX_PRIO_LOW;
  wire hit_phi = in_range && reg_idx == IDX_PRIO_HIGH;
  wire hit_flg = in_range && reg_idx == IDX_INT_FLAGS;
  wire hit_svc = in_range && reg_idx == IDX_SERVICE;
  wire mapped = hit_pc || hit_opt || hit_p1w || hit_ien || hit_plo ||
    hit_phi || hit_flg || hit_svc;
  wire wr_pc = wr_en && hit_pc;
  wire wr_opt = wr_en && hit_opt;
  wire wr_p1w = wr_en && hit_p1w;
  wire wr_ien = wr_en && hit_ien;
  wire wr_plo = wr_en && hit_plo;
  wire wr_phi = wr_en && hit_phi;
  wire wr_flg = wr_en && hit_flg;

  // event detection
  wire [2:0] ext_en = {int_enable[SRC_EXT2], int_enable[SRC_EXT1],
    int_enable[SRC_EXT0]};
  wire [2:0] ext_fall = ext_prev & ~ext_pin_input;
  // a pin change counts only on pins whose wake bit is set
  wire p1_change = |((p1_prev ^ port1_pin) & port1_wake_enable);
  wire [10:0] pin_set = {2'b00, ext_fall[2], p1_change, 4'b0000,
    ext_fall[1], 1'b0, ext_fall[0]};
  wire [10:0] set_mask = src_event | pin_set;
  wire [10:0] clr_mask = wr_flg ? pwdata[10:0] : 11'h000;
  wire [10:0] live = flags & int_enable;
  wire wake_idle = |live;
  // timers cannot run in stop, so only pin sources may end it
  wire wake_stop = |(live & PIN_SRC_MASK);
  // an enabled pin already low would wake at once; refuse instead
  wire stop_block = |(~ext_pin_input & ext_en);
  wire mode_wake;

  // hardware set wins over software clear
  always_comb begin
    next_flags = (flags & ~clr_mask) | set_mask;
  end

  assign rdata_mux =
    hit_pc ? {24'h000000, baud_doubler, 3'b000, general_flag_b,
      general_flag_a, power_down_request, sleep_cpu_request} :
    hit_opt ? {24'h000000, option} :
    hit_p1w ? {24'h000000, port1_wake_enable} :
    hit_ien ? {16'h0000, global_enable, 4'h0, int_enable} :
    hit_plo ? {21'h000000, prio_low} :
    hit_phi ? {21'h000000, prio_high} :
    hit_flg ? {21'h000000, flags} :
    hit_svc ? {svc.vector, 11'h000, svc.req, svc.active} :
    32'h00000000;

  // apb answers with one wait state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? rdata_mux : 32'h00000000;
    end
  end

  // power control; wake clears the request bits on the mode change edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sleep_cpu_request <= PC_RESET[PC_IDLE];
      power_down_request <= PC_RESET[PC_STOP];
      general_flag_a <= PC_RESET[PC_GF_A];
      general_flag_b <= PC_RESET[PC_GF_B];
      baud_doubler <= PC_RESET[PC_BAUD];
    end else begin
      if (mode_wake) begin
        sleep_cpu_request <= 1'b0;
        power_down_request <= 1'b0;
      end else if (wr_pc) begin
        sleep_cpu_request <= pwdata[PC_IDLE];
        power_down_request <= pwdata[PC_STOP] && !stop_block;
      end
      if (wr_pc) begin
        general_flag_a <= pwdata[PC_GF_A];
        general_flag_b <= pwdata[PC_GF_B];
        baud_doubler <= pwdata[PC_BAUD];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      option <= OPT_RESET;
      port1_wake_enable <= P1W_RESET;
    end else begin
      if (wr_opt) begin
        option <= pwdata[7:0];
      end
      if (wr_p1w) begin
        port1_wake_enable <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_enable <= 11'h000;
      global_enable <= 1'b0;
      prio_low <= 11'h000;
      prio_high <= 11'h000;
    end else begin
      if (wr_ien) begin
        int_enable <= pwdata[10:0];
        global_enable <= pwdata[GLOBAL_EN];
      end
      if (wr_plo) begin
        prio_low <= pwdata[10:0];
      end
      if (wr_phi) begin
        prio_high <= pwdata[10:0];
      end
    end
  end

  // external pins idle high; reset value avoids a false edge after release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags <= 11'h000;
      ext_prev <= 3'b111;
      p1_prev <= 8'h00;
    end else begin
      flags <= next_flags;
      ext_prev <= ext_pin_input;
      p1_prev <= port1_pin;
    end
  end

  assign svc.pending = flags;
  assign svc.enable = int_enable;
  assign svc.global_en = global_enable;
  assign svc.prio_lo = prio_low;
  assign svc.prio_hi = prio_high;
  assign svc.ack = irq_ack;
  assign svc.ret = irq_return;
  assign irq_req = svc.req;
  assign irq_vector = svc.vector;

  pmi_arbiter u_arbiter (
    .clk(clk),
    .rst_b(rst_b),
    .svc(svc)
  );

  pmi_mode_ctl u_mode (
    .clk(clk),
    .rst_b(rst_b),
    .idle_req(sleep_cpu_request),
    .stop_req(power_down_request),
    .periph_halt(option[OPT_PCH]),
    .wake_idle(wake_idle),
    .wake_stop(wake_stop),
    .wake(mode_wake),
    .cpu_run(cpu_run),
    .sysclk_en(sysclk_en),
    .periph_clk_en(periph_clk_en),
    .timer_serial_clk_en(timer_serial_clk_en)
  );

  chk_stop_refused: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_pc && pwdata[PC_STOP] && stop_block) |=> !power_down_request)
    else $error("stop entered with enabled pin low");
  chk_idle_entry: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(sleep_cpu_request) && !power_down_request) |=>
      (!cpu_run && sysclk_en && periph_clk_en))
    else $error("idle entry clocks wrong");
  chk_stop_clocks: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(power_down_request) |=>
      (!cpu_run && !sysclk_en && !periph_clk_en && !timer_serial_clk_en))
    else $error("stop left a clock running");
  chk_wake_clears: assert property (@(posedge clk) disable iff (!rst_b)
    mode_wake |=> (!sleep_cpu_request && !power_down_request))
    else $error("wake did not clear request bits");
  chk_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
    (src_event != 11'h000) |=>
      ((flags & $past(src_event)) == $past(src_event)))
    else $error("event lost its flag");
  chk_p1_masked: assert property (@(posedge clk) disable iff (!rst_b)
    (((p1_prev ^ port1_pin) & port1_wake_enable) == 8'h00 &&
      !src_event[SRC_P1] && !flags[SRC_P1]) |=> !flags[SRC_P1])
    else $error("masked port1 pin set its flag");
  chk_apb_ready: assert property (@(posedge clk) disable iff (!rst_b)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered");
  cov_idle_entry: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(sleep_cpu_request));
  cov_stop_refuse: cover property (@(posedge clk) disable iff (!rst_b)
    wr_pc && pwdata[PC_STOP] && stop_block);
  // pin sources must land in their own flag slots, not a neighbour's
  chk_ext0_set: assert property (@(posedge clk) disable iff (!rst_b)
    ext_fall[0] |=> flags[SRC_EXT0])
    else $error("pin 0 fall lost its flag");
  chk_ext1_set: assert property (@(posedge clk) disable iff (!rst_b)
    ext_fall[1] |=> flags[SRC_EXT1])
    else $error("pin 1 fall lost its flag");
  chk_ext2_set: assert property (@(posedge clk) disable iff (!rst_b)
    ext_fall[2] |=> flags[SRC_EXT2])
    else $error("pin 2 fall lost its flag");
  chk_p1_set: assert property (@(posedge clk) disable iff (!rst_b)
    p1_change |=> flags[SRC_P1])
    else $error("port1 change lost its flag");
  chk_apb_error: assert property (@(posedge clk) disable iff (!rst_b)
    access |=> (pslverr == !$past(mapped)))
    else $error("apb error flag wrong");
  // read data is zero outside the answer cycle
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !pready |-> prdata == 32'h00000000)
    else $error("read data outside answer cycle");
  cov_p1_flag: cover property (@(posedge clk) disable iff (!rst_b)
    p1_change);
endmodule // pmi_top
`default_nettype wire

// ==== dv/pmi_cpu_model.sv ====
// Purpose: cpu side of the interrupt handshake, driven from the bench
// Assumes: one clock, the bench commands the end of each routine
// Notes: ack waits ack_delay cycles of request, so prompt or slow
`timescale 1ns/100ps
`default_nettype none
module pmi_cpu_model (
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic irq_req, // request from the block
  input wire logic ack_en, // cpu willing to take requests
  input wire logic [3:0] ack_delay, // request cycles before ack
  input wire logic ret_cmd, // bench ends the innermost routine
  output logic irq_ack, // one-cycle take pulse
  output logic irq_return // one-cycle end of routine
);
  logic [3:0] wait_cnt;
  logic take;
  // never a second ack for the same request, it drops after the first
  assign take = irq_req && !irq_ack && ack_en && (wait_cnt >= ack_delay);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end else begin
      wait_cnt <= (irq_req && wait_cnt != 4'hF) ? wait_cnt + 4'h1 : 4'h0;
      irq_ack <= take;
      irq_return <= ret_cmd;
    end
  end
endmodule // pmi_cpu_model
`default_nettype wire

// ==== dv/pmi_top_test.sv ====
// Purpose: self-checking bench of the power-mode and interrupt block
// Assumes: apb slave answers with one wait state
// Notes: flags and active levels are mirrored in a small bench model
`timescale 1ns/100ps
`default_nettype none
module pmi_top_test;
  import pmi_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic irq_ack, irq_return, irq_req, ack_en, ret_cmd, baud_doubler;
  logic cpu_run, sysclk_en, periph_clk_en, timer_serial_clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [10:0] src_event;
  logic [2:0] ext_pin_input;
  logic [7:0] port1_pin;
  logic [15:0] irq_vector;
  logic [3:0] ack_delay;
  int fail_count, comparisons, flags_m;
  int act_q[$];

  pmi_top u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_event, .ext_pin_input, .port1_pin,
    .irq_ack, .irq_return, .irq_req, .irq_vector, .cpu_run, .sysclk_en,
    .periph_clk_en, .timer_serial_clk_en, .baud_doubler);
  pmi_cpu_model u_cpu (.clk, .rst_b, .irq_req, .ack_en, .ack_delay,
    .ret_cmd, .irq_ack, .irq_return);

  always #20 clk = ~clk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      fail_count++;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx,
      input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    src_event <= 11'h001 << i;
    flags_m |= 1 << i;
    @(posedge clk);
    src_event <= 11'h000;
  endtask

  function automatic logic [31:0] exp_vec(input int i);
    return 3 + 8 * ((i < 6) ? i : i + 1);
  endfunction

  function automatic logic [31:0] act_bits();
    logic [31:0] b;
    b = 0;
    foreach (act_q[k]) b[act_q[k]] = 1'b1;
    return b;
  endfunction

  // waits for the cpu to take a request, then checks its vector
  task automatic serve(input int i, input int lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_ack !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
    check("irq_vector", {16'h0000, irq_vector}, exp_vec(i));
    act_q.push_back(lvl);
  endtask

  task automatic clr(input int i);
    wr(IDX_INT_FLAGS, 32'h1 << i);
    flags_m &= ~(1 << i);
  endtask

  // flag cleared before return, else the source fires again at once
  task automatic retire(input int i);
    clr(i);
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    void'(act_q.pop_back());
  endtask

  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end

  initial begin
    clk = 0;
    rst_b = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    src_event = 0;
    ext_pin_input = 3'h7;
    port1_pin = 0;
    ack_en = 1;
    ack_delay = 0;
    ret_cmd = 0;
    fail_count = 0;
    comparisons = 0;
    flags_m = 0;
    rnd = $urandom(33);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("power_control", IDX_POWER_CONTROL, PC_RESET);
    rdchk("option", IDX_OPTION, OPT_RESET);
    rdchk("port1_wake_enable", IDX_PORT1_WAKE, P1W_RESET);
    apb(1'b0, 8'h10, 32'h0);
    check("pslverr", err, 1);
    rnd = $urandom & 32'h8C;
    wr(IDX_POWER_CONTROL, rnd);
    rdchk("power_control", IDX_POWER_CONTROL, rnd);
    check("baud_doubler", baud_doubler, rnd[7]);
    for (int i = 0; i < NSRC; i++) begin
      ack_delay <= 4'($urandom % 4);
      wr(IDX_INT_ENABLE, (i % 2) ? (32'h87FF ^ (1 << i)) : (1 << i));
      pulse(i);
      rdchk("flags", IDX_INT_FLAGS, flags_m);
      check("irq_req", irq_req, 0);
      wr(IDX_INT_ENABLE, 32'h8000 | (1 << i));
      serve(i, 0);
      retire(i);
    end
    // levels: source 1 at 1, 3 at 1, 4 at 3
    wr(IDX_PRIO_LOW, 32'h1A);
    wr(IDX_PRIO_HIGH, 32'h10);
    wr(IDX_INT_ENABLE, 32'h801A);
    pulse(1);
    serve(1, 1);
    pulse(3);
    repeat (4) @(posedge clk);
    check("irq_req", irq_req, 0);
    pulse(4);
    serve(4, 3);
    apb(1'b0, IDX_SERVICE, 32'h0);
    check("active", rd & 32'hF, act_bits());
    retire(4);
    repeat (4) @(posedge clk);
    check("irq_req", irq_req, 0);
    retire(1);
    serve(3, 1);
    retire(3);
    ack_delay <= 4'h3;
    wr(IDX_OPTION, OPT_RESET | 32'h20);
    wr(IDX_INT_ENABLE, 32'h8002);
    wr(IDX_POWER_CONTROL, 32'h01);
    repeat (2) @(posedge clk);
    check("cpu_run", cpu_run, 0);
    check("sysclk_en", sysclk_en, 1);
    check("periph_clk_en", periph_clk_en, 1);
    check("timer_serial_clk_en", timer_serial_clk_en, 0);
    pulse(5);
    repeat (4) @(posedge clk);
    check("cpu_run", cpu_run, 0);
    pulse(1);
    serve(1, 1);
    check("cpu_run", cpu_run, 1);
    retire(1);
    clr(5);
    rdchk("power_control", IDX_POWER_CONTROL, 32'h0);
    ack_en <= 1'b0;
    wr(IDX_INT_ENABLE, 32'h8003);
    @(posedge clk);
    ext_pin_input <= 3'h6;
    flags_m |= 1;
    wr(IDX_POWER_CONTROL, 32'h02);
    rdchk("power_control", IDX_POWER_CONTROL, 32'h0);
    check("sysclk_en", sysclk_en, 1);
    clr(0);
    @(posedge clk);
    ext_pin_input <= 3'h7;
    wr(IDX_POWER_CONTROL, 32'h02);
    repeat (2) @(posedge clk);
    check("clock enables", {cpu_run, sysclk_en, periph_clk_en,
      timer_serial_clk_en}, 0);
    pulse(1);
    repeat (4) @(posedge clk);
    check("sysclk_en", sysclk_en, 0);
    @(posedge clk);
    ext_pin_input <= 3'h6;
    flags_m |= 1;
    repeat (6) @(posedge clk);
    check("sysclk_en", sysclk_en, 1);
    rdchk("power_control", IDX_POWER_CONTROL, 32'h0);
    ack_en <= 1'b1;
    serve(1, 1);
    retire(1);
    serve(0, 0);
    retire(0);
    @(posedge clk);
    ext_pin_input <= 3'h7;
    wr(IDX_INT_ENABLE, 32'h0);
    rnd = ($urandom & 32'hFC) | 32'h1;
    wr(IDX_PORT1_WAKE, rnd);
    rdchk("port1_wake_enable", IDX_PORT1_WAKE, rnd);
    @(posedge clk);
    port1_pin <= 8'h02;
    repeat (3) @(posedge clk);
    rdchk("flags", IDX_INT_FLAGS, flags_m);
    @(posedge clk);
    port1_pin <= 8'h03;
    flags_m |= 1 << 7;
    repeat (3) @(posedge clk);
    rdchk("flags", IDX_INT_FLAGS, flags_m);
    // idle again with the timer halt option off
    wr(IDX_OPTION, OPT_RESET);
    wr(IDX_INT_ENABLE, 32'h8002);
    wr(IDX_POWER_CONTROL, 32'h01);
    repeat (2) @(posedge clk);
    check("cpu_run", cpu_run, 0);
    check("timer_serial_clk_en", timer_serial_clk_en, 1);
    pulse(1);
    serve(1, 1);
    check("cpu_run", cpu_run, 1);
    retire(1);
    rdchk("power_control", IDX_POWER_CONTROL, 32'h0);
    wrap_up;
  end
endmodule // pmi_top_test
`default_nettype wire
